// ---- shared/load_unit_pkg.sv ----
`default_nettype none

package load_unit_pkg;

	// Shape of one general register and of the bank.
	localparam int REG_W      = 24;
	localparam int BYTE_W     = 8;
	localparam int INSTR_W    = 16;
	localparam int REG_COUNT  = 8;
	localparam int IDX_W      = 3;

	// Register layout: upper byte on top, byte 0 in the middle, byte 1 lowest.
	localparam int UPPER_LSB  = 16;
	localparam int BYTE0_LSB  = 8;
	localparam int BYTE1_LSB  = 0;

	// Register 0 is the instruction address register.
	localparam logic [2:0]  IAR_IDX     = 3'h0;
	localparam logic [23:0] REG_RESET   = 24'h00_0000;
	localparam logic [23:0] IAR_STEP    = 24'h00_0002;

	// Leading pattern of the immediate byte load.
	localparam logic [4:0]  IMM_PREFIX  = 5'h10;

	// Low byte patterns of the register-form loads.
	localparam logic [7:0]  OPC_FULL       = 8'h88;
	localparam logic [7:0]  OPC_FULL_SH    = 8'hf8;
	localparam logic [7:0]  OPC_HALF       = 8'h80;
	localparam logic [7:0]  OPC_HALF_SH    = 8'hf0;
	localparam logic [7:0]  OPC_BYTE       = 8'h08;
	localparam logic [7:0]  OPC_BYTE_SH    = 8'h78;

	// Sequencer states, one-hot.
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_EXEC = 2'b10
	} state_t;

	// Condition latches.
	typedef struct packed {
		logic c;
		logic z;
	} cond_t;

	localparam cond_t COND_RESET = 2'h0;

	// Fields of a captured instruction word.
	typedef struct packed {
		logic [2:0] source_reg_field;
		logic [1:0] source_pair;
		logic       source_byte_select;
		logic [2:0] target_reg_field;
		logic [1:0] target_pair;
		logic       target_byte_select;
		logic [7:0] low_byte;
		logic [4:0] prefix;
		logic       top_bit;
		logic       mid_bit;
	} fields_t;

endpackage

`default_nettype wire

// ---- design/register_load_instruction_unit.sv ----
// What this block does
// - Each general register is 24 bits: upper byte, byte 0, byte 1.
// - Register 0 is the instruction address; writing it redirects the next fetch.
// - Immediate byte load writes the immediate into byte 0 or byte 1 only.
// - Two-bit register fields form the upper address bits; lowest bit forced to one.
// - Immediate load sets first latch if byte nonzero, null latch if zero.
// - Full copy moves all three bytes, keeps source, updates latches from target.
// - Full copy: first latch on nonzero 24-bit result, null latch on zero.
// - Full-group loads to register 0 branch and leave both latches unchanged.
// - Halfword copy moves bytes 0 and 1 only; target upper byte kept.
// - Halfword copy: first latch on nonzero 16-bit result, null latch on zero.
// - Byte copy moves selected source byte into selected target byte only.
// - Byte copies: first latch on even one-count or zero, null latch on zero.
// - Full shifted load shifts source right one, zero into top bit.
// - Full and halfword shifted loads set first latch from the shifted-out bit.
// - Full shifted load sets null latch when the 24-bit result is zero.
// - Halfword shifted load shifts bytes 0 and 1 right one, upper byte kept.
// - Halfword shifted load sets null latch when the 16-bit result is zero.
// - Byte shifted load shifts selected byte right one into selected target byte.
`timescale 1ns/100ps
`default_nettype none

module register_load_instruction_unit (
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// Instruction issue.
	input  wire logic        instr_valid_in,
	input  wire logic [15:0] instr_in,
	output logic             ready_out,
	output logic             done_out,
	output logic             illegal_out,
	output logic             branch_out,
	// Condition latches and instruction address.
	output logic             c_latch_out,
	output logic             z_latch_out,
	output logic [23:0]      iar_out,
	// Register preload and readback.
	input  wire logic        preload_en_in,
	input  wire logic [2:0]  preload_sel_in,
	input  wire logic [23:0] preload_data_in,
	input  wire logic [2:0]  read_sel_in,
	output logic [23:0]      read_data_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Two-bit register fields only reach odd registers.
	function automatic logic [2:0] force_odd(input logic [1:0] pair);
		force_odd = {pair, 1'b1};
	endfunction

	// Picks byte 0 or byte 1 of a register.
	function automatic logic [7:0] get_byte(input logic [23:0] r, input logic sel);
		get_byte = sel ? r[load_unit_pkg::BYTE1_LSB +: 8] : r[load_unit_pkg::BYTE0_LSB +: 8];
	endfunction

	// Replaces byte 0 or byte 1 of a register, keeping the rest.
	function automatic logic [23:0] put_byte(input logic [23:0] r, input logic sel,
			input logic [7:0] b);
		put_byte = sel ? {r[23:8], b} : {r[23:16], b, r[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	logic [23:0]            regs_q [load_unit_pkg::REG_COUNT];
	logic [15:0]            instr_q;
	load_unit_pkg::state_t  state_q;
	load_unit_pkg::state_t  state_d;
	load_unit_pkg::cond_t   cond_q;
	load_unit_pkg::cond_t   cond_d;
	logic                   ready_q;
	logic                   done_q;
	logic                   illegal_q;
	logic                   branch_q;
	logic [23:0]            read_q;

	////////////////////////////////////////////////////////////////////////////////
	// Field extraction and decode.

	load_unit_pkg::fields_t f;
	wire logic              exec_now;
	wire logic              rr_form;
	wire logic              op_imm;
	wire logic              op_full;
	wire logic              op_full_sh;
	wire logic              op_half;
	wire logic              op_half_sh;
	wire logic              op_byte;
	wire logic              op_byte_sh;
	wire logic              full_group;
	wire logic              byte_group;
	wire logic              legal;
	wire logic              take_now;

	// Bit 0 of the instruction is the most significant bit of the word.
	assign f.top_bit            = instr_q[15];
	assign f.source_reg_field   = instr_q[14:12];
	assign f.source_pair        = instr_q[14:13];
	assign f.source_byte_select = instr_q[12];
	assign f.mid_bit            = instr_q[11];
	assign f.target_reg_field   = instr_q[10:8];
	assign f.target_pair        = instr_q[10:9];
	assign f.target_byte_select = instr_q[8];
	assign f.low_byte           = instr_q[7:0];
	assign f.prefix             = instr_q[15:11];

	// Opcode recognition; the immediate form uses its low byte as data.
	assign exec_now   = (state_q == load_unit_pkg::S_EXEC);
	assign rr_form    = !f.top_bit && !f.mid_bit;
	assign op_imm     = (f.prefix == load_unit_pkg::IMM_PREFIX);
	assign op_full    = rr_form && (f.low_byte == load_unit_pkg::OPC_FULL);
	assign op_full_sh = rr_form && (f.low_byte == load_unit_pkg::OPC_FULL_SH);
	assign op_half    = rr_form && (f.low_byte == load_unit_pkg::OPC_HALF);
	assign op_half_sh = rr_form && (f.low_byte == load_unit_pkg::OPC_HALF_SH);
	assign op_byte    = rr_form && (f.low_byte == load_unit_pkg::OPC_BYTE);
	assign op_byte_sh = rr_form && (f.low_byte == load_unit_pkg::OPC_BYTE_SH);
	assign full_group = op_full || op_full_sh || op_half || op_half_sh;
	assign byte_group = op_byte || op_byte_sh;
	assign legal      = op_imm || full_group || byte_group;
	// An offer is taken only once ready is shown, so the first cycle after reset stays closed.
	assign take_now   = (state_q == load_unit_pkg::S_IDLE) && ready_q && instr_valid_in &&
		!preload_en_in;

	////////////////////////////////////////////////////////////////////////////////
	// Operand selection.

	wire logic [2:0]  src_idx_c;
	wire logic [2:0]  tgt_idx_c;
	wire logic [23:0] src_full;
	wire logic [23:0] tgt_full;
	wire logic [23:0] tgt_c;
	wire logic [7:0]  src_c;
	wire logic        src_lsb;

	// Three-bit fields address registers directly; two-bit ones are forced odd.
	assign src_full  = regs_q[f.source_reg_field];
	assign tgt_full  = regs_q[f.target_reg_field];
	assign src_idx_c = force_odd(f.source_pair);
	assign tgt_idx_c = force_odd(f.target_pair);
	assign tgt_c     = regs_q[tgt_idx_c];
	assign src_c     = get_byte(regs_q[src_idx_c], f.source_byte_select);
	assign src_lsb   = src_full[load_unit_pkg::BYTE1_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// Results.

	wire logic [23:0] res_full;
	wire logic [23:0] res_full_sh;
	wire logic [23:0] res_half;
	wire logic [23:0] res_half_sh;
	wire logic [7:0]  byte_val;
	wire logic [23:0] res_byte;
	wire logic [23:0] res_imm;
	wire logic [23:0] wr_data;
	wire logic [2:0]  wr_idx;
	wire logic        to_iar;

	// Each form writes a whole register; untouched bytes are read back unchanged.
	assign res_full    = src_full;
	assign res_full_sh = {1'b0, src_full[23:1]};
	assign res_half    = {tgt_full[23:16], src_full[15:0]};
	assign res_half_sh = {tgt_full[23:16], 1'b0, src_full[15:1]};
	assign byte_val    = op_byte_sh ? {1'b0, src_c[7:1]} : src_c;
	assign res_byte    = put_byte(tgt_c, f.target_byte_select, byte_val);
	assign res_imm     = put_byte(tgt_c, f.target_byte_select, f.low_byte);

	// Write steering.
	assign wr_idx  = full_group ? f.target_reg_field : tgt_idx_c;
	assign wr_data = op_full    ? res_full    :
	                 op_full_sh ? res_full_sh :
	                 op_half    ? res_half    :
	                 op_half_sh ? res_half_sh :
	                 op_imm     ? res_imm     : res_byte;
	// Only the full group can name register 0; byte forms are always odd.
	assign to_iar  = full_group && (f.target_reg_field == load_unit_pkg::IAR_IDX);

	////////////////////////////////////////////////////////////////////////////////
	// Condition latch update.

	wire logic [7:0] latch_byte;

	// Byte forms test the byte written; the immediate tests for nonzero only.
	assign latch_byte = op_imm ? f.low_byte : byte_val;

	// A branch through register 0 holds the latches, since they then describe an address.
	always_comb begin
		cond_d = cond_q;
		if (exec_now && legal && !to_iar) begin
			unique case (1'b1)
				op_imm: begin
					cond_d.c = (latch_byte != 8'h00);
					cond_d.z = (latch_byte == 8'h00);
				end
				op_full: begin
					cond_d.c = (res_full != 24'h00_0000);
					cond_d.z = (res_full == 24'h00_0000);
				end
				op_half: begin
					cond_d.c = (res_half[15:0] != 16'h0000);
					cond_d.z = (res_half[15:0] == 16'h0000);
				end
				op_full_sh: begin
					cond_d.c = src_lsb;
					cond_d.z = (res_full_sh == 24'h00_0000);
				end
				op_half_sh: begin
					cond_d.c = src_lsb;
					cond_d.z = (res_half_sh[15:0] == 16'h0000);
				end
				default: begin
					cond_d.c = ~^latch_byte;
					cond_d.z = (latch_byte == 8'h00);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: capture one cycle, execute the next.

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			load_unit_pkg::S_IDLE: begin
				if (take_now) begin
					state_d = load_unit_pkg::S_EXEC;
				end
			end
			load_unit_pkg::S_EXEC: begin
				state_d = load_unit_pkg::S_IDLE;
			end
		endcase
	end

	// State, instruction capture and one-cycle status pulses.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q   <= load_unit_pkg::S_IDLE;
			instr_q   <= 16'h0000;
			cond_q    <= load_unit_pkg::COND_RESET;
			ready_q   <= 1'b0;
			done_q    <= 1'b0;
			illegal_q <= 1'b0;
			branch_q  <= 1'b0;
		end else begin
			state_q   <= state_d;
			cond_q    <= cond_d;
			ready_q   <= (state_d == load_unit_pkg::S_IDLE);
			done_q    <= exec_now && legal;
			illegal_q <= exec_now && !legal;
			branch_q  <= exec_now && to_iar;
			if (take_now) begin
				instr_q <= instr_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register bank.

	// The address register advances by one halfword unless it is the target itself;
	// a preload is only taken while idle so it never races an execute.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < load_unit_pkg::REG_COUNT; i++) begin
				regs_q[i] <= load_unit_pkg::REG_RESET;
			end
		end else if (exec_now && legal) begin
			regs_q[wr_idx] <= wr_data;
			if (!to_iar) begin
				regs_q[load_unit_pkg::IAR_IDX] <= regs_q[load_unit_pkg::IAR_IDX] +
					load_unit_pkg::IAR_STEP;
			end
		end else if (state_q == load_unit_pkg::S_IDLE && preload_en_in) begin
			regs_q[preload_sel_in] <= preload_data_in;
		end
	end

	// Registered readback port.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			read_q <= load_unit_pkg::REG_RESET;
		end else begin
			read_q <= regs_q[read_sel_in];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign ready_out     = ready_q;
	assign done_out      = done_q;
	assign illegal_out   = illegal_q;
	assign branch_out    = branch_q;
	assign c_latch_out   = cond_q.c;
	assign z_latch_out   = cond_q.z;
	assign iar_out       = regs_q[load_unit_pkg::IAR_IDX];
	assign read_data_out = read_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	// Helper flops that remember the last write for the commit check.
	logic [2:0]  chk_idx_q;
	logic [23:0] chk_data_q;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chk_idx_q  <= 3'h0;
			chk_data_q <= 24'h00_0000;
		end else begin
			chk_idx_q  <= wr_idx;
			chk_data_q <= wr_data;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	property p_commit;
		exec_now && legal |=> regs_q[chk_idx_q] == chk_data_q;
	endproperty
	a_commit: assert property (p_commit) else $error("register write not committed");

	property p_iar_step;
		exec_now && legal && !to_iar |=> iar_out == $past(iar_out) + load_unit_pkg::IAR_STEP;
	endproperty
	a_iar_step: assert property (p_iar_step) else $error("address did not step");

	property p_imm_byte;
		exec_now && op_imm |-> get_byte(wr_data, f.target_byte_select) == f.low_byte
			&& wr_data[23:16] == tgt_c[23:16];
	endproperty
	a_imm_byte: assert property (p_imm_byte) else $error("immediate byte misplaced");

	property p_odd_target;
		exec_now && (op_imm || byte_group) |-> wr_idx[0];
	endproperty
	a_odd_target: assert property (p_odd_target) else $error("even register reached");

	property p_imm_latch;
		exec_now && op_imm |=> c_latch_out == ($past(f.low_byte) != 8'h00)
			&& z_latch_out == !c_latch_out;
	endproperty
	a_imm_latch: assert property (p_imm_latch) else $error("immediate latches wrong");

	property p_full_latch;
		exec_now && op_full && !to_iar |=> z_latch_out == ($past(src_full) == 24'h00_0000)
			&& c_latch_out != z_latch_out;
	endproperty
	a_full_latch: assert property (p_full_latch) else $error("full copy latches wrong");

	property p_branch;
		exec_now && to_iar |=> branch_out && $stable(c_latch_out) && $stable(z_latch_out)
			&& iar_out == $past(wr_data) ##1 !branch_out;
	endproperty
	a_branch: assert property (p_branch) else $error("branch through register 0 wrong");

	property p_half_keep;
		exec_now && (op_half || op_half_sh) |-> wr_data[23:16] == tgt_full[23:16];
	endproperty
	a_half_keep: assert property (p_half_keep) else $error("upper byte disturbed");

	property p_shift_full;
		exec_now && op_full_sh |-> wr_data == {1'b0, src_full[23:1]};
	endproperty
	a_shift_full: assert property (p_shift_full) else $error("full shift wrong");

	property p_shift_carry;
		exec_now && (op_full_sh || op_half_sh) && !to_iar |=> c_latch_out == $past(src_lsb);
	endproperty
	a_shift_carry: assert property (p_shift_carry) else $error("shifted-out bit lost");

	property p_byte_latch;
		exec_now && byte_group |=> c_latch_out == ~^$past(byte_val)
			&& z_latch_out == ($past(byte_val) == 8'h00);
	endproperty
	a_byte_latch: assert property (p_byte_latch) else $error("byte latches wrong");

	property p_one_shot;
		instr_valid_in && ready_out && !preload_en_in |=> !ready_out ##1 (done_out || illegal_out);
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("issue not answered in two cycles");

	c_imm:     cover property (exec_now && op_imm);
	c_branch:  cover property (exec_now && to_iar);
	c_byte_sh: cover property (exec_now && op_byte_sh);
	c_illegal: cover property (exec_now && !legal);

endmodule // register_load_instruction_unit

`default_nettype wire

// ---- test/register_load_instruction_unit_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module register_load_instruction_unit_test;

	////////////////////////////////////////////////////////////////////////////////
	// Stimulus, observed outputs and the bench's own copy of the register bank.
	logic        clock_in = 1'b0;
	logic        rst_n_in;
	logic        instr_valid_in;
	logic [15:0] instr_in;
	logic        preload_en_in;
	logic [2:0]  preload_sel_in;
	logic [23:0] preload_data_in;
	logic [2:0]  read_sel_in;
	logic        ready_out;
	logic        done_out;
	logic        illegal_out;
	logic        branch_out;
	logic        c_latch_out;
	logic        z_latch_out;
	logic [23:0] iar_out;
	logic [23:0] read_data_out;
	logic [23:0] m [8];
	logic        exp_c;
	logic        exp_z;
	int          err_count = 0;
	int          comparisons = 0;
	int          cycles = 0;

	// A 40 ns period gives the 25 MHz processor clock.
	always #20 clock_in = ~clock_in;

	register_load_instruction_unit u_dut (
		.clock_in        (clock_in),
		.rst_n_in        (rst_n_in),
		.instr_valid_in  (instr_valid_in),
		.instr_in        (instr_in),
		.ready_out       (ready_out),
		.done_out        (done_out),
		.illegal_out     (illegal_out),
		.branch_out      (branch_out),
		.c_latch_out     (c_latch_out),
		.z_latch_out     (z_latch_out),
		.iar_out         (iar_out),
		.preload_en_in   (preload_en_in),
		.preload_sel_in  (preload_sel_in),
		.preload_data_in (preload_data_in),
		.read_sel_in     (read_sel_in),
		.read_data_out   (read_data_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// The whole run needs a few hundred cycles, so this ceiling only trips on a hang.
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Every register is read back, since a stray write to an untouched one must show.
	task automatic check_all();
		for (int i = 0; i < 8; i++) begin
			read_sel_in = 3'(i);
			@(posedge clock_in);
			#1;
			if (i == 0) chk({23'h0, done_out}, 24'h00_0000);
			chk(read_data_out, m[i]);
		end
		chk({22'h0, c_latch_out, z_latch_out}, {22'h0, exp_c, exp_z});
		chk(iar_out, m[0]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Expected effect of one instruction word, worked out from the field layout.
	task automatic model(input logic [15:0] w, output logic ill, output logic br);
		logic [23:0] s;
		logic [23:0] t;
		logic [23:0] r;
		logic [2:0]  ti;
		logic [7:0]  b;
		ill = 1'b0;
		br = 1'b0;
		if (w[15:11] == 5'b10000) begin
			ti = {w[10:9], 1'b1};
			b = w[7:0];
			if (w[8]) m[ti][7:0] = b;
			else m[ti][15:8] = b;
			exp_c = (b != 8'h00);
			exp_z = (b == 8'h00);
			m[0] = m[0] + 24'h00_0002;
		end else if (w[15] || w[11]) begin
			ill = 1'b1;
		end else if (w[7:0] == 8'h08 || w[7:0] == 8'h78) begin
			s = m[{w[14:13], 1'b1}];
			ti = {w[10:9], 1'b1};
			b = w[12] ? s[7:0] : s[15:8];
			if (w[7:0] == 8'h78) b = b >> 1;
			if (w[8]) m[ti][7:0] = b;
			else m[ti][15:8] = b;
			exp_c = ~^b;
			exp_z = (b == 8'h00);
			m[0] = m[0] + 24'h00_0002;
		end else if (w[7:0] inside {8'h88, 8'hf8, 8'h80, 8'hf0}) begin
			s = m[w[14:12]];
			ti = w[10:8];
			t = m[ti];
			r = (w[7:0] == 8'h88) ? s : (w[7:0] == 8'hf8) ? (s >> 1) :
				(w[7:0] == 8'h80) ? {t[23:16], s[15:0]} : {t[23:16], 1'b0, s[15:1]};
			if (ti == 3'h0) begin
				br = 1'b1;
			end else begin
				exp_c = w[4] ? s[0] : (w[3] ? (r != 24'h00_0000) : (r[15:0] != 16'h0000));
				exp_z = w[3] ? (r == 24'h00_0000) : (r[15:0] == 16'h0000);
				m[0] = m[0] + 24'h00_0002;
			end
			m[ti] = r;
		end else begin
			ill = 1'b1;
		end
	endtask

	// Offers one word; hold of 2 keeps it up through the busy edge, where it must be ignored.
	task automatic issue(input logic [15:0] w, input int hold);
		logic ill;
		logic br;
		int   n;
		n = 0;
		while (ready_out !== 1'b1 && n < 10) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		model(w, ill, br);
		instr_valid_in = 1'b1;
		instr_in = w;
		@(posedge clock_in);
		#1;
		if (hold == 1) instr_valid_in = 1'b0;
		@(posedge clock_in);
		#1;
		instr_valid_in = 1'b0;
		chk({21'h0, done_out, illegal_out, branch_out}, {21'h0, ~ill, ill, br});
		check_all();
	endtask

	task automatic preload(input logic [2:0] sel, input logic [23:0] d);
		preload_en_in = 1'b1;
		preload_sel_in = sel;
		preload_data_in = d;
		@(posedge clock_in);
		#1;
		preload_en_in = 1'b0;
		m[sel] = d;
		@(posedge clock_in);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_imm();
		for (int k = 0; k < 8; k++)
			issue({5'b10000, 3'(k), (k == 3) ? 8'h00 : 8'(8'h1d * (k + 1))}, 1);
	endtask

	task automatic t_full();
		preload(3'h6, 24'ha5_3c01);
		preload(3'h2, 24'h00_0000);
		preload(3'h5, 24'h12_0000);
		issue({1'b0, 3'h6, 1'b0, 3'h3, 8'h88}, 1);
		issue({1'b0, 3'h2, 1'b0, 3'h7, 8'h88}, 1);
		issue({1'b0, 3'h5, 1'b0, 3'h4, 8'h80}, 1);
		issue({1'b0, 3'h6, 1'b0, 3'h1, 8'h80}, 1);
		issue({1'b0, 3'h6, 1'b0, 3'h0, 8'h88}, 1);
		issue({1'b0, 3'h5, 1'b0, 3'h0, 8'h80}, 1);
	endtask

	task automatic t_byte();
		preload(3'h1, 24'hff_8107);
		preload(3'h3, 24'h77_0000);
		for (int k = 0; k < 4; k++) begin
			issue({1'b0, 2'b00, k[0], 1'b0, 2'b01, k[1], 8'h08}, 1);
			issue({1'b0, 2'b00, k[0], 1'b0, 2'b10, k[1], 8'h78}, 1);
		end
		preload(3'h7, 24'hee_0000);
		issue({1'b0, 2'b11, 1'b0, 1'b0, 2'b01, 1'b1, 8'h08}, 1);
	endtask

	task automatic t_shift();
		preload(3'h7, 24'h80_0001);
		preload(3'h4, 24'hab_0003);
		preload(3'h6, 24'hcd_ffff);
		preload(3'h2, 24'h00_0001);
		issue({1'b0, 3'h7, 1'b0, 3'h5, 8'hf8}, 1);
		issue({1'b0, 3'h2, 1'b0, 3'h3, 8'hf8}, 1);
		issue({1'b0, 3'h4, 1'b0, 3'h6, 8'hf0}, 1);
		issue({1'b0, 3'h2, 1'b0, 3'h1, 8'hf0}, 1);
		preload(3'h2, 24'h00_0002);
		issue({1'b0, 3'h2, 1'b0, 3'h1, 8'hf0}, 1);
		issue({1'b0, 3'h7, 1'b0, 3'h0, 8'hf8}, 1);
		issue({1'b0, 3'h4, 1'b0, 3'h0, 8'hf0}, 1);
	endtask

	// Three malformed words must leave registers, latches and the address alone; 16'h8088 and the held full copy are legal.
	task automatic t_illegal();
		issue(16'h0888, 1);
		issue(16'hc000, 1);
		issue(16'h1012, 1);
		issue(16'h8088, 1);
		issue({1'b0, 3'h6, 1'b0, 3'h3, 8'h88}, 2);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rst_n_in = 1'b0;
		instr_valid_in = 1'b0;
		instr_in = 16'h0000;
		preload_en_in = 1'b0;
		preload_sel_in = 3'h0;
		preload_data_in = 24'h00_0000;
		read_sel_in = 3'h0;
		m = '{default: 24'h00_0000};
		exp_c = 1'b0;
		exp_z = 1'b0;
		repeat (5) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		@(posedge clock_in);
		#1;
		chk({23'h0, ready_out}, 24'h00_0001);
		check_all();
		t_imm();
		t_full();
		t_byte();
		t_shift();
		t_illegal();
		give_verdict();
	end

endmodule // register_load_instruction_unit_test

`default_nettype wire
